/* File: sim/mdes_host_model.sv */
// host driver model: register bus cycles, flag clearing, poll demand, software reset
`timescale 1ns/1ps
module mdes_host_model
    import mdes_pkg::*;
(
    input  wire logic     i_clk,     // bus clock
    output mdes_bus_req_t o_bus,     // register bus request
    output logic          o_rx_poll  // receive poll demand pulse
);
    // ****************************************
    // bus cycles, driven just after an edge
    // ****************************************
    initial begin
        o_bus     = '0;  // idle from time zero
        o_rx_poll = 1'b0;
    end
    // one-cycle write strobe; the slave never stalls
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_clk);
        o_bus <= '0;
    endtask
    // one-cycle read strobe; data is watched by the bench monitor
    task automatic rd(input logic [7:0] addr);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0000_0000};
        @(posedge i_clk);
        o_bus <= '0;
    endtask
    // write ones to drop sticky flags
    task automatic clear(input logic [31:0] bits);
        wr(MDES_STATUS_OFS, bits);
    endtask
    // only way back onto the bus after a fatal error
    task automatic soft_reset();
        wr(MDES_CTRL_OFS, 32'h0000_0001);
    endtask
    // descriptor handed back, then poll demand
    task automatic poll();
        @(posedge i_clk);
        o_rx_poll <= 1'b1;
        @(posedge i_clk);
        o_rx_poll <= 1'b0;
    endtask
endmodule // mdes_host_model

/* File: sim/mdes_status_tb.sv */
// self-checking bench for the dma event status block
`timescale 1ns/1ps
module mdes_status_tb
    import mdes_pkg::*;
;
    logic           i_clk, i_rst_n, recog, rx_poll, rd_seen, bus_en, uf, irq;
    mdes_bus_req_t  bus;          // from host model
    logic [31:0]    rdata, rnd;
    mdes_events_t   ev;           // event pulses
    logic [2:0]     bek_in, tx_exp, rx_exp, bek_exp;
    mdes_tx_state_t tx_in, tx_out;
    mdes_rx_state_t rx_in, rx_out;
    int             n_fail, checks_done;
    logic [31:0]    exp_q[$];     // expected read data, oldest first
    int             ev_idx[5] = '{8, 6, 4, 2, 1};
    int             st_bit[5] = '{0, 3, 6, 9, 11};

    mdes_host_model mdes_host_model_inst (.i_clk(i_clk), .o_bus(bus), .o_rx_poll(rx_poll));
    mdes_status mdes_status_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_ev(ev), .i_bus_err_kind(bek_in), .i_tx_state(tx_in), .i_rx_state(rx_in),
        .i_rx_frame_recognised(recog), .i_rx_poll(rx_poll), .o_tx_state(tx_out),
        .o_rx_state(rx_out), .o_bus_enable(bus_en), .o_tx_desc_underflow(uf), .o_irq(irq));

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    // expected status word from flags plus tracked fields
    function automatic logic [31:0] stat(input logic [31:0] f);
        logic [31:0] e;
        e = f;
        e[MDES_NORSUM_B] = |(f & MDES_NORMAL_MASK);
        e[MDES_ABNSUM_B] = |(f & MDES_ABNORM_MASK);
        e[19:17] = rx_exp;
        e[22:20] = tx_exp;
        e[25:23] = bek_exp;
        return e;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        mdes_host_model_inst.rd(a);
    endtask
    task automatic pulse(input mdes_events_t e);
        @(posedge i_clk);
        ev <= e;
        @(posedge i_clk);
        ev <= '0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // read monitor: data stands one cycle after the strobe
    // ****************************************
    always @(posedge i_clk) rd_seen <= bus.rd;
    always @(negedge i_clk) begin
        if (rd_seen) begin
            check(rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 32'hFFFF_FFFF, "read");
        end
    end
    // watchdog, far beyond the few hundred cycles used
    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        give_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        i_rst_n = 1'b0;
        ev = '0;
        bek_in = 3'h0;
        recog = 1'b0;
        tx_in = MDES_TX_STOP;
        rx_in = MDES_RX_STOP;
        tx_exp = 3'h0;
        rx_exp = 3'h0;
        bek_exp = 3'h0;
        n_fail = 0;
        checks_done = 0;
        rnd = 32'h0000_0048;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        expect_rd(MDES_STATUS_OFS, 32'h0000_0000);
        tx_in <= MDES_TX_SEND;
        rx_in <= MDES_RX_WAIT;
        repeat (2) @(posedge i_clk);
        tx_exp = 3'h2;
        rx_exp = 3'h3;
        // each simple event sets its flag and its summary
        for (int i = 0; i < 5; i++) begin
            pulse(mdes_events_t'(9'h001 << ev_idx[i]));
            expect_rd(MDES_STATUS_OFS, stat(32'h1 << st_bit[i]));
            mdes_host_model_inst.clear(32'h1 << st_bit[i]);
            expect_rd(MDES_STATUS_OFS, stat(32'h0));
        end
        // missing rx descriptor: first resumed by a frame, then by poll
        for (int k = 0; k < 2; k++) begin
            pulse(mdes_events_t'(9'h008));
            rx_exp = 3'h4;
            expect_rd(MDES_STATUS_OFS, stat(32'h0000_0080));
            if (k == 0) begin
                @(posedge i_clk) recog <= 1'b1;
                @(posedge i_clk) recog <= 1'b0;
            end else begin
                mdes_host_model_inst.poll();
            end
            // read descriptor again right after the frame or the poll
            #1 check({29'h0, rx_out}, 32'h0000_0001, "rx resumed");
            repeat (2) @(posedge i_clk);
            rx_exp = 3'h3;
            mdes_host_model_inst.clear(32'h0000_0080);
            expect_rd(MDES_STATUS_OFS, stat(32'h0));
        end
        // both engines enter stop
        rx_in <= MDES_RX_STOP;
        tx_in <= MDES_TX_STOP;
        repeat (2) @(posedge i_clk);
        rx_exp = 3'h0;
        tx_exp = 3'h0;
        expect_rd(MDES_STATUS_OFS, stat(32'h0000_0102));
        rx_in <= MDES_RX_WAIT;
        tx_in <= MDES_TX_SEND;
        mdes_host_model_inst.clear(32'h0000_0102);
        rx_exp = 3'h3;
        tx_exp = 3'h2;
        expect_rd(MDES_STATUS_OFS, stat(32'h0));
        // underflow marks descriptor and suspends, then tx missing joins
        pulse(mdes_events_t'(9'h020));
        // the engine reports suspend from now on; the forced cycle is checked first
        tx_in <= MDES_TX_SUSPEND;
        #1 check({31'h0, uf}, 32'h1, "underflow mark");
        check({29'h0, tx_out}, 32'h0000_0006, "tx suspended");
        tx_exp = 3'h6;
        pulse(mdes_events_t'(9'h080));
        expect_rd(MDES_STATUS_OFS, stat(32'h0000_0024));
        mdes_host_model_inst.soft_reset();
        tx_in <= MDES_TX_SEND;
        repeat (3) @(posedge i_clk);
        tx_exp = 3'h2;
        expect_rd(MDES_STATUS_OFS, stat(32'h0));
        // every bus error kind; a second error while halted is not recorded
        for (int k = 0; k < 3; k++) begin
            bek_in <= k[2:0];
            pulse(mdes_events_t'(9'h001));
            bek_in <= 3'((k + 1) % 3);
            #1 check({31'h0, bus_en}, 32'h0, "bus halt");
            pulse(mdes_events_t'(9'h001));
            bek_exp = k[2:0];
            expect_rd(MDES_STATUS_OFS, stat(32'h0000_2000));
            mdes_host_model_inst.soft_reset();
            repeat (3) @(posedge i_clk);
            check({31'h0, bus_en}, 32'h1, "bus back");
            bek_exp = 3'h0;
        end
        // interrupt: only the enabled flag drives it
        mdes_host_model_inst.wr(MDES_MASK_OFS, 32'h0000_0001);
        pulse(mdes_events_t'(9'h002));
        #1 check({31'h0, irq}, 32'h0, "masked irq");
        pulse(mdes_events_t'(9'h100));
        #1 check({31'h0, irq}, 32'h1, "irq");
        mdes_host_model_inst.clear(32'h0000_0001);
        #1 check({31'h0, irq}, 32'h0, "irq cleared");
        mdes_host_model_inst.clear(32'h0000_0800);
        // random words: mask storage, read-only fields, unmapped place
        for (int k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            mdes_host_model_inst.wr(MDES_MASK_OFS, rnd);
            expect_rd(MDES_MASK_OFS, rnd & MDES_EVENT_MASK);
            mdes_host_model_inst.wr(MDES_STATUS_OFS, rnd & ~MDES_EVENT_MASK);
            expect_rd(MDES_STATUS_OFS, stat(32'h0));
            mdes_host_model_inst.wr(8'h3C, rnd);
            expect_rd(8'h3C, 32'h0000_0000);
        end
        // mid-run hardware reset drops a pending flag and the mask
        pulse(mdes_events_t'(9'h002));
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        expect_rd(MDES_MASK_OFS, 32'h0000_0000);
        expect_rd(MDES_STATUS_OFS, stat(32'h0));
        repeat (3) @(posedge i_clk);
        give_verdict();
    end
endmodule // mdes_status_tb

/* File: verilog/mdes_pkg.sv */
// package: register map, field layout, state codes and carriers of the dma event status block
package mdes_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] MDES_STATUS_OFS = 8'h28;  // dma_event_status
    localparam logic [7:0] MDES_MASK_OFS   = 8'h2C;  // interrupt mask, same layout
    localparam logic [7:0] MDES_CTRL_OFS   = 8'h30;  // control: bit 0 software reset request

    // ****************************************
    // field positions inside dma_event_status
    // ****************************************
    localparam int MDES_TXDONE_B   = 0;   // tx_frame_done
    localparam int MDES_TXSTOP_B   = 1;   // tx_stopped
    localparam int MDES_TXDMISS_B  = 2;   // tx_descriptor_missing
    localparam int MDES_TXJAB_B    = 3;   // tx_jabber_expired
    localparam int MDES_TXUF_B     = 5;   // tx_fifo_underflow
    localparam int MDES_RXDONE_B   = 6;   // rx_frame_done
    localparam int MDES_RXDMISS_B  = 7;   // rx_descriptor_missing
    localparam int MDES_RXSTOP_B   = 8;   // rx_stopped
    localparam int MDES_RXWDOG_B   = 9;   // rx_watchdog_expired
    localparam int MDES_GPTIM_B    = 11;  // general_timer_expired
    localparam int MDES_FATAL_B    = 13;  // fatal_bus_error
    localparam int MDES_ABNSUM_B   = 15;  // abnormal_summary
    localparam int MDES_NORSUM_B   = 16;  // normal_summary
    localparam int MDES_RXST_LO    = 17;  // rx_process_state
    localparam int MDES_TXST_LO    = 20;  // tx_process_state
    localparam int MDES_BEK_LO     = 23;  // bus_error_kind

    // sticky event bits: 0,1,2,3,5,6,7,8,9,11,13
    localparam logic [31:0] MDES_EVENT_MASK  = 32'h0000_2BEF;
    localparam logic [31:0] MDES_NORMAL_MASK = 32'h0000_0045;  // bits 0,2,6
    localparam logic [31:0] MDES_ABNORM_MASK = 32'h0000_2BAA;  // bits 1,3,5,7,8,9,11,13
    localparam logic [31:0] MDES_ZERO32      = 32'h0000_0000;

    // ****************************************
    // codes
    // ****************************************
    typedef enum logic [2:0] {
        MDES_BE_PARITY = 3'h0,
        MDES_BE_MABORT = 3'h1,
        MDES_BE_TABORT = 3'h2
    } mdes_bus_err_t;

    typedef enum logic [2:0] {
        MDES_TX_STOP    = 3'h0,
        MDES_TX_RDDESC  = 3'h1,
        MDES_TX_SEND    = 3'h2,
        MDES_TX_FILL    = 3'h3,
        MDES_TX_SUSPEND = 3'h6,
        MDES_TX_WRDESC  = 3'h7
    } mdes_tx_state_t;

    typedef enum logic [2:0] {
        MDES_RX_STOP    = 3'h0,
        MDES_RX_RDDESC  = 3'h1,
        MDES_RX_CHECK   = 3'h2,
        MDES_RX_WAIT    = 3'h3,
        MDES_RX_SUSPEND = 3'h4,
        MDES_RX_WRDESC  = 3'h5,
        MDES_RX_FLUSH   = 3'h6,
        MDES_RX_DRAIN   = 3'h7
    } mdes_rx_state_t;

    // one-cycle event pulses from the dma engines
    typedef struct packed {
        logic tx_frame_done;
        logic tx_descriptor_missing;
        logic tx_jabber_expired;
        logic tx_fifo_underflow;
        logic rx_frame_done;
        logic rx_descriptor_missing;
        logic rx_watchdog_expired;
        logic general_timer_expired;
        logic bus_error;
    } mdes_events_t;

    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mdes_bus_req_t;
endpackage

/* File: verilog/mdes_status.sv */
// dma event status register with process state tracking and interrupt output
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

// What this block does
// - three-bit bus error kind, valid with fatal flag
// - read-only transmit process state code, no interrupt
// - read-only receive process state code, no interrupt
// - normal summary from tx/rx completion, tx-missing
// - abnormal summary from the eight abnormal flags
// - bus error sets fatal flag, halts bus
// - general timer expiry sets its flag
// - watchdog expiry outside receive stop sets flag
// - receive entering stop sets its flag
// - missing rx descriptor flags and suspends
// - recognised frame resumes suspended receive
// - each finished frame sets receive completed
// - underflow sets flag and marks descriptor
// - underflow suspends transmit, not stop
// - flags stay set until one written or a software reset
module mdes_status
    import mdes_pkg::*;
(
    input  wire logic           i_clk,          // 200 MHz bus clock
    input  wire logic           i_rst_n,        // synchronous, active low
    input  wire mdes_bus_req_t  i_bus,          // register bus request
    output logic [31:0]         o_rdata,        // read data, cycle after read
    input  wire mdes_events_t   i_ev,           // event pulses
    input  wire logic [2:0]     i_bus_err_kind, // cause, with i_ev.bus_error
    input  wire mdes_tx_state_t i_tx_state,     // tx engine requested state
    input  wire mdes_rx_state_t i_rx_state,     // rx engine requested state
    input  wire logic           i_rx_frame_recognised, // frame passed address filter
    input  wire logic           i_rx_poll,      // receive poll demand written
    output mdes_tx_state_t      o_tx_state,     // reported tx state
    output mdes_rx_state_t      o_rx_state,     // reported rx state
    output logic                o_bus_enable,   // low: no system bus access
    output logic                o_tx_desc_underflow, // mark underflow in descriptor status
    output logic                o_irq           // level interrupt
);

    // ****************************************
    // state
    // ****************************************
    logic [31:0]    ev_q, ev_d;        // sticky event flags
    logic [31:0]    mask_q, mask_d;    // interrupt mask
    logic [2:0]     bek_q, bek_d;      // bus error kind
    logic           halt_q, halt_d;    // bus halted after fatal error
    logic           uf_q, uf_d;        // descriptor underflow mark
    mdes_tx_state_t txs_q, txs_d;      // tx process state
    mdes_rx_state_t rxs_q, rxs_d;      // rx process state
    logic [31:0]    rdata_q, rdata_d;  // registered read data
    logic [31:0]    status;            // assembled status word
    logic [31:0]    set_v;             // event set vector
    logic           soft_rst;          // software reset strobe
    logic           norm_sum;          // normal summary
    logic           abn_sum;           // abnormal summary

    assign soft_rst = i_bus.wr && (i_bus.addr == MDES_CTRL_OFS) && i_bus.wdata[0];

    // ****************************************
    // process state tracking
    // ****************************************
    // underflow and missing descriptors force suspend over the engine's request
    always_comb begin
        txs_d = i_tx_state;
        if (i_ev.tx_fifo_underflow || i_ev.tx_descriptor_missing) begin
            txs_d = MDES_TX_SUSPEND;
        end
        rxs_d = i_rx_state;
        if (i_ev.rx_descriptor_missing) begin
            rxs_d = MDES_RX_SUSPEND;
        end else if (rxs_q == MDES_RX_SUSPEND && (i_rx_poll || i_rx_frame_recognised)) begin
            rxs_d = MDES_RX_RDDESC;
        end else if (rxs_q == MDES_RX_SUSPEND && i_rx_state != MDES_RX_STOP) begin
            rxs_d = MDES_RX_SUSPEND;                 // hold until poll, frame or a stop request
        end
        if (soft_rst) begin
            txs_d = MDES_TX_STOP;
            rxs_d = MDES_RX_STOP;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            txs_q <= MDES_TX_STOP;
            rxs_q <= MDES_RX_STOP;
        end else begin
            txs_q <= txs_d;
            rxs_q <= rxs_d;
        end
    end

    // ****************************************
    // sticky flags, bus halt, descriptor mark
    // ****************************************
    // set wins over a same-cycle write-one clear
    always_comb begin
        set_v = MDES_ZERO32;
        set_v[MDES_TXDONE_B]  = i_ev.tx_frame_done;
        set_v[MDES_TXSTOP_B]  = (txs_d == MDES_TX_STOP) && (txs_q != MDES_TX_STOP);
        set_v[MDES_TXDMISS_B] = i_ev.tx_descriptor_missing;
        set_v[MDES_TXJAB_B]   = i_ev.tx_jabber_expired;
        set_v[MDES_TXUF_B]    = i_ev.tx_fifo_underflow;
        set_v[MDES_RXDONE_B]  = i_ev.rx_frame_done;
        set_v[MDES_RXDMISS_B] = i_ev.rx_descriptor_missing;
        set_v[MDES_RXSTOP_B]  = (rxs_d == MDES_RX_STOP) && (rxs_q != MDES_RX_STOP);
        // watchdog only counts while the receive process is not stopped
        set_v[MDES_RXWDOG_B]  = i_ev.rx_watchdog_expired && (rxs_q != MDES_RX_STOP);
        set_v[MDES_GPTIM_B]   = i_ev.general_timer_expired;
        set_v[MDES_FATAL_B]   = i_ev.bus_error && !halt_q;
        ev_d = ev_q;
        if (i_bus.wr && i_bus.addr == MDES_STATUS_OFS) begin
            ev_d = ev_q & ~(i_bus.wdata & MDES_EVENT_MASK);
        end
        ev_d = ev_d | set_v;
        mask_d = mask_q;
        if (i_bus.wr && i_bus.addr == MDES_MASK_OFS) begin
            mask_d = i_bus.wdata & MDES_EVENT_MASK;
        end
        // first error's cause is kept; later ones are blocked by the halt
        bek_d  = (set_v[MDES_FATAL_B]) ? i_bus_err_kind : bek_q;
        // only software reset reopens the bus
        halt_d = soft_rst ? 1'b0 : (halt_q | i_ev.bus_error);
        uf_d   = i_ev.tx_fifo_underflow;
        if (soft_rst) begin
            ev_d  = MDES_ZERO32;
            bek_d = MDES_BE_PARITY;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ev_q   <= MDES_ZERO32;
            mask_q <= MDES_ZERO32;
            bek_q  <= MDES_BE_PARITY;
            halt_q <= 1'b0;
            uf_q   <= 1'b0;
        end else begin
            ev_q   <= ev_d;
            mask_q <= mask_d;
            bek_q  <= bek_d;
            halt_q <= halt_d;
            uf_q   <= uf_d;
        end
    end

    // ****************************************
    // summaries and status word
    // ****************************************
    assign norm_sum = |(ev_q & MDES_NORMAL_MASK);
    assign abn_sum  = |(ev_q & MDES_ABNORM_MASK);

    // state codes are reported but never reach the interrupt
    always_comb begin
        status = ev_q & MDES_EVENT_MASK;
        status[MDES_ABNSUM_B] = abn_sum;
        status[MDES_NORSUM_B] = norm_sum;
        status[MDES_RXST_LO +: 3] = rxs_q;
        status[MDES_TXST_LO +: 3] = txs_q;
        status[MDES_BEK_LO +: 3]  = bek_q;
    end

    // ****************************************
    // read port
    // ****************************************
    // unmapped addresses read zero
    always_comb begin
        rdata_d = MDES_ZERO32;
        if (i_bus.rd && i_bus.addr == MDES_STATUS_OFS) begin
            rdata_d = status;
        end else if (i_bus.rd && i_bus.addr == MDES_MASK_OFS) begin
            rdata_d = mask_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= MDES_ZERO32;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata             = rdata_q;
    assign o_tx_state          = txs_q;
    assign o_rx_state          = rxs_q;
    assign o_bus_enable        = !halt_q;
    assign o_tx_desc_underflow = uf_q;
    assign o_irq               = |(ev_q & mask_q);

    // ****************************************
    // assertions
    // ****************************************
    property p_fatal_halts;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.bus_error && !soft_rst) |=> (ev_q[MDES_FATAL_B] && !o_bus_enable);
    endproperty
    a_fatal_halts: assert property (p_fatal_halts) else $error("bus error did not halt");

    property p_bek_kept;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.bus_error && !halt_q && !soft_rst) |=> (bek_q == $past(i_bus_err_kind));
    endproperty
    a_bek_kept: assert property (p_bek_kept) else $error("bus error kind not captured");

    property p_uf_suspend;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.tx_fifo_underflow && !soft_rst) |=> (txs_q == MDES_TX_SUSPEND && ev_q[MDES_TXUF_B] && o_tx_desc_underflow);
    endproperty
    a_uf_suspend: assert property (p_uf_suspend) else $error("underflow not suspended");

    property p_rdu_suspend;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.rx_descriptor_missing && !soft_rst) |=> (rxs_q == MDES_RX_SUSPEND && ev_q[MDES_RXDMISS_B]);
    endproperty
    a_rdu_suspend: assert property (p_rdu_suspend) else $error("rx missing not suspended");

    property p_set_wins;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.rx_frame_done && !soft_rst) |=> ev_q[MDES_RXDONE_B];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("rx done lost");

    property p_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ev_q[MDES_GPTIM_B] && !(i_bus.wr && i_bus.addr == MDES_STATUS_OFS && i_bus.wdata[MDES_GPTIM_B])
         && !soft_rst) |=> ev_q[MDES_GPTIM_B];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

    property p_norm_sum;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == MDES_STATUS_OFS) |=>
            (o_rdata[MDES_NORSUM_B] == $past(ev_q[MDES_TXDONE_B] | ev_q[MDES_TXDMISS_B] | ev_q[MDES_RXDONE_B]));
    endproperty
    a_norm_sum: assert property (p_norm_sum) else $error("normal summary wrong");

    property p_abn_sum;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == MDES_STATUS_OFS) |=>
            (o_rdata[MDES_ABNSUM_B] == $past(|(ev_q & MDES_ABNORM_MASK)));
    endproperty
    a_abn_sum: assert property (p_abn_sum) else $error("abnormal summary wrong");

    property p_rx_stop_flag;
        @(posedge i_clk) disable iff (!i_rst_n)
        (rxs_q != MDES_RX_STOP && rxs_d == MDES_RX_STOP && !soft_rst) |=> ev_q[MDES_RXSTOP_B];
    endproperty
    a_rx_stop_flag: assert property (p_rx_stop_flag) else $error("rx stop flag missing");

    // ****************************************
    // resume, timers, halt and descriptor mark
    // ****************************************
    // a recognised frame alone must restart a suspended receive
    property p_resume;
        @(posedge i_clk) disable iff (!i_rst_n)
        (rxs_q == MDES_RX_SUSPEND && i_rx_frame_recognised && !i_ev.rx_descriptor_missing && !soft_rst)
            |=> (rxs_q == MDES_RX_RDDESC);
    endproperty
    a_resume: assert property (p_resume) else $error("suspended receive not resumed");

    // general timer expiry is never gated
    property p_gptim_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.general_timer_expired && !soft_rst) |=> ev_q[MDES_GPTIM_B];
    endproperty
    a_gptim_set: assert property (p_gptim_set) else $error("timer flag missing");

    // watchdog expiry only counts while the receiver is not stopped
    property p_wdog_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ev.rx_watchdog_expired && rxs_q != MDES_RX_STOP && !soft_rst) |=> ev_q[MDES_RXWDOG_B];
    endproperty
    a_wdog_set: assert property (p_wdog_set) else $error("watchdog flag missing");

    // once halted, the bus stays shut until software reset
    property p_halt_held;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!o_bus_enable && !soft_rst) |=> !o_bus_enable;
    endproperty
    a_halt_held: assert property (p_halt_held) else $error("bus reopened without reset");

    // entry to transmit stop raises an abnormal contributor
    property p_tx_stop_flag;
        @(posedge i_clk) disable iff (!i_rst_n)
        (txs_q != MDES_TX_STOP && txs_d == MDES_TX_STOP && !soft_rst) |=> ev_q[MDES_TXSTOP_B];
    endproperty
    a_tx_stop_flag: assert property (p_tx_stop_flag) else $error("tx stop flag missing");

    // descriptor mark is a one-cycle echo, never a stale level
    property p_uf_mark;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!i_ev.tx_fifo_underflow) |=> !o_tx_desc_underflow;
    endproperty
    a_uf_mark: assert property (p_uf_mark) else $error("stray descriptor underflow mark");

    c_underflow: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ev.tx_fifo_underflow ##1 o_tx_desc_underflow);
    c_fatal: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_ev.bus_error ##1 soft_rst);
    c_resume: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        rxs_q == MDES_RX_SUSPEND ##1 i_rx_frame_recognised);
    c_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_irq ##1 !o_irq);

endmodule // mdes_status
